// >>> sim/pce_event_select_test.sv
module pce_event_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pce_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int CW = 16;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    pce_bus_s bus_req = '0;
    logic [BUS_DW-1:0] bus_rdata;
    pce_events_s ev_cfg = '0;
    pce_events_s events;
    logic slow = 1'b0;
    logic [31:0] tb_step = 32'h0000_0001;
    logic [31:0] tb_lower;
    logic ee = 1'b1;
    logic [1:0] fe = 2'h0;
    logic be = 1'b0;
    logic irq = 1'b0;
    logic [CW-1:0] cnt;
    logic counting;
    int bad_count = 0;
    int check_count = 0;

    always #5 clk_sys = ~clk_sys;

    pce_event_select #(.CNT_W(CW)) pce_event_select_i (
        .clk_sys(clk_sys), .srst(srst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .events(events), .tb_lower(tb_lower),
        .external_interrupt_enable(ee), .float_exception_mode_bits(fe),
        .branch_trace_enable(be), .counter_irq(irq),
        .perf_counter_two(cnt), .counting(counting)
    );

    pce_pipe_model pce_pipe_model_i (
        .clk_sys(clk_sys), .srst(srst), .cfg(ev_cfg), .slow(slow),
        .tb_step(tb_step), .events(events), .tb_lower(tb_lower)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [BUS_AW-1:0] a, logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(logic [BUS_AW-1:0] a, logic [31:0] exp, string what);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: ZERO_WORD, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 chk(what, exp, bus_rdata);
        @(posedge clk_sys);
        #1 chk({what, " after"}, ZERO_WORD, bus_rdata);
    endtask

    // Counts the chosen event over n clock cycles, then holds and compares
    task automatic measure(logic [31:0] ctrl, int n, int exp, string what);
        wr(ADDR_CNT2, ZERO_WORD);
        wr(ADDR_MMC0, ctrl);
        repeat (n - 2) @(posedge clk_sys);
        wr(ADDR_MMC0, MMC0_RST);
        #1 chk(what, 32'(exp), {16'h0000, cnt});
    endtask

    task automatic chk_ev(pce_sel_t sel, int k, int exp,
                          logic [4:0] lv = 5'h08);
        pce_events_s e;
        e = '0;
        case (k)
            1: e = '1;
            2: e.completed_cnt = INC_MAX;
            4: e.dispatched_cnt = INC_MAX;
            5: e.dispatched_cnt = 3'h3;
            6: e.load_miss_busy = 1'b1;
            7: e.dcache_miss = 1'b1;
            8: e.itlb_miss = 1'b1;
            9: e.branch_code = BR_ONE;
            10: e.branch_code = BR_TWO;
            11: e.branch_code = BR_BAD;
            12: e.resv_ok = 1'b1;
            13: e.spr_read_disp = 1'b1;
            14: e.icbi = 1'b1;
            15: e.flush_sc = 1'b1;
            16: e.fp_exc = 1'b1;
            17: e.so_set = 1'b1;
            18: e.branch_result = 1'b1;
            19: e.multi_result = 1'b1;
            20: e.disp_branch = 1'b1;
            21: e.disp_single0 = 1'b1;
            22: e.disp_multi = 1'b1;
            23: e.snoop_hit = 1'b1;
            24: e.fpu_idle = 1'b1;
            25: e.flush_isync = 1'b1;
            26: e.flush_xer_move = 1'b1;
            27: e.str_zero_len = 1'b1;
            default: e = '0;
        endcase
        @(posedge clk_sys);
        ev_cfg <= e;
        {slow, ee, fe, be} <= lv;
        measure({26'h000_0000, sel}, 6, exp, $sformatf("event %h", sel));
        @(posedge clk_sys);
        ev_cfg <= '0;
        {slow, ee, fe, be} <= 5'h08;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        #1 chk("count reset", ZERO_WORD, {16'h0000, cnt});
        chk("counting reset", ZERO_WORD, {31'h0, counting});
        rd(ADDR_MMC0, MMC0_RST, "ctrl reset");
        rd(ADDR_STAT, ZERO_WORD, "status reset");
    endtask

    task automatic t_regs;
        wr(ADDR_MMC0, 32'hA5A5_0300);
        rd(ADDR_MMC0, 32'hA5A5_0300, "ctrl readback");
        wr(ADDR_MMC0, 32'h0000_0001);
        wr(ADDR_CNT2, 32'h0001_0100);
        #1 chk("load wins", 32'h0000_0100, {16'h0000, cnt});
        rd(ADDR_CNT2, 32'h0000_0101, "count read");
        wr(ADDR_MMC0, MMC0_RST);
        wr(4'hC, 32'hFFFF_FFFF);
        rd(4'hC, ZERO_WORD, "unmapped read");
        rd(ADDR_MMC0, MMC0_RST, "ctrl untouched");
    endtask

    task automatic t_table;
        chk_ev(EV_HOLD, 1, 0);
        chk_ev(6'h0E, 1, 0);
        chk_ev(6'h3F, 1, 0);
        chk_ev(EV_CYCLES, 0, 6);
        chk_ev(EV_COMPLETED, 2, 24);
        chk_ev(EV_DISPATCHED, 4, 24);
        chk_ev(EV_DISPATCHED, 5, 18);
        chk_ev(EV_LDMISS_CYC, 6, 6);
        chk_ev(EV_DC_MISS, 7, 6);
        chk_ev(EV_DC_MISS, 7, 3, 5'h18);
        chk_ev(EV_ITLB_MISS, 8, 6);
        chk_ev(EV_BRANCH, 9, 6);
        chk_ev(EV_BRANCH, 10, 12);
        chk_ev(EV_BRANCH, 11, 0);
        chk_ev(EV_RESV_OK, 12, 6);
        chk_ev(EV_SPR_READ, 13, 6);
        chk_ev(EV_ICBI, 14, 6);
        chk_ev(EV_FLUSH, 15, 6);
        chk_ev(EV_FLUSH, 16, 6);
        chk_ev(EV_FLUSH, 16, 0, 5'h0A);
        chk_ev(EV_FLUSH, 9, 6, 5'h09);
        chk_ev(EV_FLUSH, 17, 6);
        chk_ev(EV_FLUSH, 25, 6);
        chk_ev(EV_FLUSH, 26, 6);
        chk_ev(EV_FLUSH, 27, 6);
        chk_ev(EV_BRANCH_RES, 18, 6);
        chk_ev(EV_MULTI_RES, 19, 6);
        chk_ev(EV_DISP_BRANCH, 20, 6);
        chk_ev(EV_DISP_SINGLE0, 21, 6);
        chk_ev(EV_DISP_MULTI, 22, 6);
        chk_ev(EV_SNOOP_HIT, 23, 6);
        chk_ev(EV_EE_OFF, 0, 6, 5'h00);
        chk_ev(EV_EE_OFF, 0, 0);
        chk_ev(EV_FPU_IDLE, 24, 6);
        chk_ev(EV_FOUR_DISP, 4, 6);
        chk_ev(EV_FOUR_DISP, 5, 0);
    endtask

    task automatic t_tb;
        int idx[4];
        idx = '{TB_IDX0, TB_IDX1, TB_IDX2, TB_IDX3};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            tb_step <= 32'h0000_0001 << idx[i];
            measure(32'(EV_TB_EDGE) | (32'(i) << TBSEL_LSB), 6, 6,
                    "time base edge");
        end
    endtask

    // A counter interrupt stops counting until the control is rewritten
    task automatic t_freeze;
        logic [CW-1:0] v;
        wr(ADDR_CNT2, ZERO_WORD);
        wr(ADDR_MMC0, 32'h0000_0001);
        #1 chk("counting on", 32'h0000_0001, {31'h0, counting});
        @(posedge clk_sys);
        irq <= 1'b1;
        @(posedge clk_sys);
        irq <= 1'b0;
        @(posedge clk_sys);
        #1 v = cnt;
        chk("counting frozen", ZERO_WORD, {31'h0, counting});
        repeat (4) @(posedge clk_sys);
        #1 chk("held count", {16'h0000, v}, {16'h0000, cnt});
        // Illegal branch flag is still sticky from the event table
        rd(ADDR_STAT, 32'h0000_0003, "status frozen");
        wr(ADDR_MMC0, 32'h0000_0001);
        #1 v = cnt;
        repeat (3) @(posedge clk_sys);
        #1 chk("resumed", 32'(v) + 32'h0000_0003, 32'(cnt));
        wr(ADDR_MMC0, MMC0_RST);
    endtask

    task automatic t_status;
        rd(ADDR_STAT, 32'h0000_0002, "bad branch flag");
        wr(ADDR_STAT, ZERO_WORD);
        rd(ADDR_STAT, ZERO_WORD, "flag cleared");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run needs a few hundred cycles; this leaves wide margin
    initial begin
        #300000;
        bad_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        end_sim;
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset;
        t_regs;
        t_table;
        t_tb;
        t_freeze;
        t_status;
        end_sim;
    end
endmodule

// >>> sim/pce_pipe_model.sv
module pce_pipe_model
    import pce_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Stimulus from the bench
    input wire pce_events_s cfg,
    input wire logic slow,
    input wire logic [31:0] tb_step,
    // Toward the counter block
    output pce_events_s events,
    output logic [31:0] tb_lower
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Pipeline strobes and time base
    // ------------------------------------------------------------
    logic phase_r;

    // Slow mode offers strobes on alternate cycles only
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_r <= 1'b0;
            events <= '0;
            tb_lower <= 32'h0000_0000;
        end else begin
            phase_r <= ~phase_r;
            events <= (slow && phase_r) ? pce_events_s'('0) : cfg;
            // Step set per tap so the chosen bit flips every cycle
            tb_lower <= tb_lower + tb_step;
        end
    end
endmodule

// >>> src/pce_event_select.sv
module pce_event_select
    import pce_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Register port
    input wire pce_bus_s bus_req,
    output logic [BUS_DW-1:0] bus_rdata,
    // Pipeline event strobes
    input wire pce_events_s events,
    input wire logic [31:0] tb_lower,
    input wire logic external_interrupt_enable,
    input wire logic [1:0] float_exception_mode_bits,
    input wire logic branch_trace_enable,
    input wire logic counter_irq,
    // Counter state
    output logic [CNT_W-1:0] perf_counter_two,
    output logic counting
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (CNT_W < 8 || CNT_W > BUS_DW) begin : g_bad_width
        $error("pce_event_select: CNT_W must lie in 8..32");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [2:0] bit_inc(input logic hit);
        bit_inc = hit ? INC_ONE : INC_ZERO;
    endfunction

    function automatic logic [2:0] branch_inc(input logic [1:0] code);
        logic [2:0] v;
        v = INC_ZERO;
        if (code == BR_ONE) begin
            v = INC_ONE;
        end else if (code == BR_TWO) begin
            v = INC_TWO;
        end
        branch_inc = v;
    endfunction

    // Multi-count inputs above four are clipped, not trusted
    function automatic logic [2:0] clip_inc(input logic [2:0] n);
        clip_inc = (n > INC_MAX) ? INC_MAX : n;
    endfunction

    // ------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------
    logic [BUS_DW-1:0] mmc0_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic frozen_r;
    logic badbr_r;
    logic [3:0] tb_prev_r;
    logic [BUS_DW-1:0] rdata_r;

    wire wr_mmc0 = bus_req.wr && bus_req.addr == ADDR_MMC0;
    wire wr_cnt = bus_req.wr && bus_req.addr == ADDR_CNT2;
    wire wr_stat = bus_req.wr && bus_req.addr == ADDR_STAT;
    wire pce_sel_t sel = mmc0_r[SEL_LSB +: SEL_W];
    wire logic [TBSEL_W-1:0] tb_sel = mmc0_r[TBSEL_LSB +: TBSEL_W];

    // ------------------------------------------------------------
    // Event derivation
    // ------------------------------------------------------------
    wire logic [3:0] tb_tap = {tb_lower[TB_IDX3], tb_lower[TB_IDX2],
                               tb_lower[TB_IDX1], tb_lower[TB_IDX0]};
    // Previous taps of all four bits, so a select change is no edge
    wire tb_edge = tb_tap[tb_sel] ^ tb_prev_r[tb_sel];
    wire fp_flush = events.fp_exc
                    && float_exception_mode_bits == FE_OFF;
    wire br_flush = branch_trace_enable
                    && events.branch_code != BR_NONE;
    wire flush_hit = events.flush_sc || events.flush_isync
                     || events.flush_xer_move || fp_flush || br_flush
                     || events.str_zero_len || events.so_set;
    wire four_disp = events.dispatched_cnt == INC_MAX;

    logic [2:0] inc;
    always_comb begin
        case (sel)
            EV_CYCLES: inc = INC_ONE;
            EV_COMPLETED: inc = clip_inc(events.completed_cnt);
            EV_TB_EDGE: inc = bit_inc(tb_edge);
            EV_DISPATCHED: inc = clip_inc(events.dispatched_cnt);
            EV_LDMISS_CYC: inc = bit_inc(events.load_miss_busy);
            EV_DC_MISS: inc = bit_inc(events.dcache_miss);
            EV_ITLB_MISS: inc = bit_inc(events.itlb_miss);
            EV_BRANCH: inc = branch_inc(events.branch_code);
            EV_RESV_OK: inc = bit_inc(events.resv_ok);
            EV_SPR_READ: inc = bit_inc(events.spr_read_disp);
            EV_ICBI: inc = bit_inc(events.icbi);
            EV_FLUSH: inc = bit_inc(flush_hit);
            EV_BRANCH_RES: inc = bit_inc(events.branch_result);
            EV_MULTI_RES: inc = bit_inc(events.multi_result);
            EV_DISP_BRANCH: inc = bit_inc(events.disp_branch);
            EV_DISP_SINGLE0: inc = bit_inc(events.disp_single0);
            EV_DISP_MULTI: inc = bit_inc(events.disp_multi);
            EV_SNOOP_HIT: inc = bit_inc(events.snoop_hit);
            EV_EE_OFF: inc = bit_inc(!external_interrupt_enable);
            EV_FPU_IDLE: inc = bit_inc(events.fpu_idle);
            EV_FOUR_DISP: inc = bit_inc(four_disp);
            // Hold code and every unassigned code add nothing
            default: inc = INC_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // A software load wins over the event of the same cycle
    always_comb begin
        cnt_nxt = cnt_r;
        if (wr_cnt) begin
            cnt_nxt = bus_req.wdata[CNT_W-1:0];
        end else if (!frozen_r) begin
            cnt_nxt = cnt_r + CNT_W'(inc);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Control and status
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mmc0_r <= MMC0_RST;
        end else if (wr_mmc0) begin
            mmc0_r <= bus_req.wdata;
        end
    end

    // Interrupt in the write cycle still stops: set beats clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            frozen_r <= 1'b0;
        end else if (counter_irq) begin
            frozen_r <= 1'b1;
        end else if (wr_mmc0) begin
            frozen_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            badbr_r <= 1'b0;
        end else if (events.branch_code == BR_BAD) begin
            badbr_r <= 1'b1;
        end else if (wr_stat) begin
            badbr_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tb_prev_r <= 4'h0;
        end else begin
            tb_prev_r <= tb_tap;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [BUS_DW-1:0] rd_mux;
    always_comb begin
        rd_mux = ZERO_WORD;
        if (bus_req.addr == ADDR_MMC0) begin
            rd_mux = mmc0_r;
        end else if (bus_req.addr == ADDR_CNT2) begin
            rd_mux = BUS_DW'(cnt_r);
        end else if (bus_req.addr == ADDR_STAT) begin
            rd_mux[STAT_FROZEN] = frozen_r;
            rd_mux[STAT_BADBR] = badbr_r;
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_r <= ZERO_WORD;
        end else begin
            rdata_r <= bus_req.rd ? rd_mux : ZERO_WORD;
        end
    end

    assign bus_rdata = rdata_r;
    assign perf_counter_two = cnt_r;
    assign counting = !frozen_r && sel != EV_HOLD;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    wire quiet = !wr_cnt && !frozen_r;

    hold_code_a: assert property (
        (sel == EV_HOLD && !wr_cnt) |=> $stable(cnt_r))
        else $error("counter moved under hold code");

    cycle_count_a: assert property (
        (sel == EV_CYCLES && quiet) ##1 (sel == EV_CYCLES && quiet)
        |=> cnt_r == $past(cnt_r, 2) + CNT_W'(2))
        else $error("cycle count not plus one per cycle");

    complete_add_a: assert property (
        (sel == EV_COMPLETED && quiet && events.completed_cnt <= INC_MAX)
        |=> cnt_r == $past(cnt_r) + CNT_W'($past(events.completed_cnt)))
        else $error("completed count not added");

    dispatch_add_a: assert property (
        (sel == EV_DISPATCHED && quiet && events.dispatched_cnt <= INC_MAX)
        |=> cnt_r == $past(cnt_r) + CNT_W'($past(events.dispatched_cnt)))
        else $error("dispatched count not added");

    cnt_load_a: assert property (
        wr_cnt |=> cnt_r == $past(bus_req.wdata[CNT_W-1:0]))
        else $error("counter load lost");

    tb_edge_a: assert property (
        (sel == EV_TB_EDGE && quiet)
        |=> cnt_r == $past(cnt_r)
            + CNT_W'($past(tb_tap[tb_sel]) != $past(tb_prev_r[tb_sel])))
        else $error("time base edge miscounted");

    branch_add_a: assert property (
        (sel == EV_BRANCH && quiet && events.branch_code == BR_TWO)
        |=> cnt_r == $past(cnt_r) + CNT_W'(2))
        else $error("two branches not added as two");

    branch_bad_a: assert property (
        (sel == EV_BRANCH && !wr_cnt && events.branch_code == BR_BAD)
        |=> $stable(cnt_r) && badbr_r)
        else $error("illegal branch code counted");

    freeze_irq_a: assert property (
        counter_irq ##1 (!wr_cnt && !wr_mmc0)[*2]
        |-> $stable(cnt_r) && frozen_r)
        else $error("counter ran after interrupt");

    unused_code_a: assert property (
        (sel == 6'h0E && !wr_cnt) |=> $stable(cnt_r))
        else $error("unassigned code moved counter");

    ee_off_a: assert property (
        (sel == EV_EE_OFF && quiet && !external_interrupt_enable)
        |=> cnt_r == $past(cnt_r) + CNT_W'(1))
        else $error("interrupt-off cycle not counted");

    four_disp_a: assert property (
        (sel == EV_FOUR_DISP && quiet && events.dispatched_cnt != INC_MAX)
        |=> $stable(cnt_r))
        else $error("four-dispatch counted without four");

    read_port_a: assert property (
        (bus_req.rd && bus_req.addr == ADDR_CNT2 && !wr_cnt)
        |=> bus_rdata == BUS_DW'($past(cnt_r)))
        else $error("counter read data wrong");

    cycles_run_c: cover property (
        sel == EV_CYCLES && quiet [*4]);
    irq_stop_c: cover property (
        counting ##1 counter_irq ##1 !counting);
    branch_two_c: cover property (
        sel == EV_BRANCH && quiet && events.branch_code == BR_TWO);
    tb_edge_c: cover property (
        sel == EV_TB_EDGE && quiet && tb_edge);

endmodule

// >>> src/pce_pkg.sv
package pce_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int BUS_AW = 4;
    localparam int BUS_DW = 32;
    localparam logic [BUS_AW-1:0] ADDR_MMC0 = 4'h0;
    localparam logic [BUS_AW-1:0] ADDR_CNT2 = 4'h4;
    localparam logic [BUS_AW-1:0] ADDR_STAT = 4'h8;
    localparam logic [BUS_DW-1:0] MMC0_RST = 32'h0000_0000;
    localparam logic [BUS_DW-1:0] ZERO_WORD = 32'h0000_0000;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    // Select sits in big-endian bits 26..31, i.e. the low six bits
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 6;
    localparam int TBSEL_LSB = 8;
    localparam int TBSEL_W = 2;
    localparam int STAT_FROZEN = 0;
    localparam int STAT_BADBR = 1;

    // ------------------------------------------------------------
    // Event select codes
    // ------------------------------------------------------------
    typedef logic [SEL_W-1:0] pce_sel_t;
    localparam pce_sel_t EV_HOLD = 6'h00;
    localparam pce_sel_t EV_CYCLES = 6'h01;
    localparam pce_sel_t EV_COMPLETED = 6'h02;
    localparam pce_sel_t EV_TB_EDGE = 6'h03;
    localparam pce_sel_t EV_DISPATCHED = 6'h04;
    localparam pce_sel_t EV_LDMISS_CYC = 6'h05;
    localparam pce_sel_t EV_DC_MISS = 6'h06;
    localparam pce_sel_t EV_ITLB_MISS = 6'h07;
    localparam pce_sel_t EV_BRANCH = 6'h08;
    localparam pce_sel_t EV_RESV_OK = 6'h09;
    localparam pce_sel_t EV_SPR_READ = 6'h0A;
    localparam pce_sel_t EV_ICBI = 6'h0B;
    localparam pce_sel_t EV_FLUSH = 6'h0C;
    localparam pce_sel_t EV_BRANCH_RES = 6'h0D;
    localparam pce_sel_t EV_MULTI_RES = 6'h0F;
    localparam pce_sel_t EV_DISP_BRANCH = 6'h28;
    localparam pce_sel_t EV_DISP_SINGLE0 = 6'h29;
    localparam pce_sel_t EV_DISP_MULTI = 6'h32;
    localparam pce_sel_t EV_SNOOP_HIT = 6'h34;
    localparam pce_sel_t EV_FOUR_DISP = 6'h35;
    localparam pce_sel_t EV_EE_OFF = 6'h37;
    localparam pce_sel_t EV_FPU_IDLE = 6'h3A;

    // ------------------------------------------------------------
    // Event encodings
    // ------------------------------------------------------------
    localparam logic [2:0] INC_ZERO = 3'h0;
    localparam logic [2:0] INC_ONE = 3'h1;
    localparam logic [2:0] INC_TWO = 3'h2;
    localparam logic [2:0] INC_MAX = 3'h4;
    localparam logic [1:0] BR_NONE = 2'h0;
    localparam logic [1:0] BR_BAD = 2'h1;
    localparam logic [1:0] BR_ONE = 2'h2;
    localparam logic [1:0] BR_TWO = 2'h3;
    localparam logic [1:0] FE_OFF = 2'h0;
    // Lower time base index of big-endian bits 47, 51, 55, 63
    localparam int TB_IDX0 = 16;
    localparam int TB_IDX1 = 12;
    localparam int TB_IDX2 = 8;
    localparam int TB_IDX3 = 0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [BUS_AW-1:0] addr;
        logic [BUS_DW-1:0] wdata;
        logic wr;
        logic rd;
    } pce_bus_s;

    typedef struct packed {
        logic [2:0] completed_cnt;
        logic [2:0] dispatched_cnt;
        logic load_miss_busy;
        logic dcache_miss;
        logic itlb_miss;
        logic [1:0] branch_code;
        logic resv_ok;
        logic spr_read_disp;
        logic icbi;
        logic flush_sc;
        logic flush_isync;
        logic flush_xer_move;
        logic fp_exc;
        logic str_zero_len;
        logic so_set;
        logic branch_result;
        logic multi_result;
        logic disp_branch;
        logic disp_single0;
        logic disp_multi;
        logic snoop_hit;
        logic fpu_idle;
    } pce_events_s;

endpackage
